/* testbench/nand_dev_model.sv */
// behavioural nand device answering the host pins
`timescale 1ns/10ps
module nand_dev_model (
    // host pins
    input  wire logic        chip_en_n_i,
    input  wire logic        cmd_latch_i,
    input  wire logic        addr_latch_i,
    input  wire logic        write_strobe_n_i,
    input  wire logic        read_strobe_n_i,
    input  wire logic [15:0] io_i,
    output logic             ready_busy_n_o,
    output logic      [15:0] io_o,
    // bench side
    input  wire logic        fail_i,
    output logic             viol_o
);
    logic [15:0] mem [int];
    logic [15:0] row, last;
    logic [8:0]  col;
    logic [7:0]  cmd = 8'h00;
    logic        spare = 1'b0, loaded = 1'b0;
    int          na = 0;
    initial ready_busy_n_o = 1'b1;
    initial viol_o = 1'b0;
    // released bus never repeats the last word
    assign io_o = read_strobe_n_i ? ~last : last;
    task automatic busy(input int ns);
        ready_busy_n_o = 1'b0;
        #(ns);
        ready_busy_n_o = 1'b1;
    endtask
    always @(posedge write_strobe_n_i) begin
        if (!chip_en_n_i && (cmd_latch_i || addr_latch_i) && io_i[15:8] != 8'h00) viol_o = 1'b1;
        if (!chip_en_n_i && cmd_latch_i && (ready_busy_n_o || io_i[7:0] == 8'h70)) begin
            cmd = io_i[7:0];
            na = 0;
            if (cmd == 8'h00 || cmd == 8'h50) spare = cmd[6];
            if (cmd == 8'h10 && loaded) begin
                loaded = 1'b0;
                fork
                    busy(400);
                join_none
            end
        end else if (!chip_en_n_i && addr_latch_i && ready_busy_n_o) begin
            if (na == 0 && spare && io_i[7:3] != 5'h00) viol_o = 1'b1;
            if (na == 0) col = spare ? {6'h20, io_i[2:0]} : {1'b0, io_i[7:0]};
            if (na == 1) row[7:0] = io_i[7:0];
            if (na == 2) row[15:8] = io_i[7:0];
            na++;
            if (na == 3 && cmd != 8'h80) begin
                fork
                    busy(200);
                join_none
            end
        end else if (!chip_en_n_i && cmd == 8'h80 && ready_busy_n_o) begin
            mem[row*512 + col] = io_i;
            col++;
            loaded = 1'b1;
        end
    end
    // next word or status on strobe fall
    // x16 single page only; fail bit comes from the bench
    always @(negedge read_strobe_n_i) begin
        if (!chip_en_n_i && cmd == 8'h70) last = {9'h001, ready_busy_n_o, 5'h00, fail_i};
        else if (!chip_en_n_i) begin
            last = mem.exists(row*512 + col) ? mem[row*512 + col] : {row[6:0], col};
            col++;
        end
    end
endmodule

/* testbench/test_nand_host.sv */
// self-checking bench for the nand host controller
`timescale 1ns/10ps
module test_nand_host;
    logic                   clock_i = 1'b0, resetn_i = 1'b0, req_valid_i = 1'b0;
    logic                   wdata_valid_i = 1'b0, rdata_ready_i = 1'b1, stall = 1'b0, fail = 1'b0, got_done = 1'b0;
    logic                   req_ready_o, wdata_ready_o, rdata_valid_o, ce_n, cle, ale, we_n, re_n, rb_n, viol;
    logic [15:0]            rdata_o, io_o, io_oe_o, io_dev, wdata_i;
    logic [15:0]            tmem [int];
    logic [15:0]            rq [$];
    int                     wi = 0, n_errors = 0, num_checks = 0;
    nand_host_pkg::req_t    req_i = '0;
    nand_host_pkg::result_t result_o, res;
    always #2 clock_i = ~clock_i;
    always @(negedge clock_i) rdata_ready_i = stall ? ~rdata_ready_i : 1'b1;
    assign wdata_i = 16'hc000 + wi[15:0];
    nand_host #(.BUSY_MAX(200)) dut_u (.clock_i, .resetn_i, .req_valid_i, .req_ready_o, .req_i, .wdata_valid_i,
        .wdata_ready_o, .wdata_i, .rdata_valid_o, .rdata_ready_i, .rdata_o, .result_o, .chip_en_n_o(ce_n),
        .cmd_latch_o(cle), .addr_latch_o(ale), .write_strobe_n_o(we_n), .read_strobe_n_o(re_n),
        .ready_busy_n_i(rb_n), .io_i(io_dev), .io_o, .io_oe_o);
    nand_dev_model dev_u (.chip_en_n_i(ce_n), .cmd_latch_i(cle), .addr_latch_i(ale), .write_strobe_n_i(we_n),
        .read_strobe_n_i(re_n), .io_i(io_o), .ready_busy_n_o(rb_n), .io_o(io_dev), .fail_i(fail), .viol_o(viol));
    always @(posedge clock_i) begin
        if (rdata_valid_o === 1'b1 && rdata_ready_i) rq.push_back(rdata_o);
        if (wdata_valid_i && wdata_ready_o === 1'b1) wi <= wi + 1;
        if (result_o.done === 1'b1) res <= result_o;
        if (result_o.done === 1'b1) got_done <= 1'b1;
    end
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic run(input nand_host_pkg::op_t o, input logic [7:0] c, input logic [15:0] r, input logic [8:0] n);
        @(negedge clock_i);
        req_i = '{o, c, r, n};
        req_valid_i = 1'b1;
        wdata_valid_i = (o == nand_host_pkg::OP_PROGRAM);
        got_done = 1'b0;
        rq.delete();
        for (int k = 0; k < 9000 && !got_done; k++) begin
            @(negedge clock_i);
            if (req_ready_o === 1'b1) req_valid_i = 1'b0;
        end
        wdata_valid_i = 1'b0;
        if (!got_done) begin
            n_errors++;
            $display("BAD %0t no completion", $time);
            conclude();
        end
    endtask
    task automatic rd(input logic sp, input logic [7:0] c, input logic [15:0] r, input logic [8:0] n);
        logic [8:0] col;
        run(sp ? nand_host_pkg::OP_READ_SPARE : nand_host_pkg::OP_READ_MAIN, c, r, n);
        chk(16'(rq.size()), {7'h00, n});
        for (int i = 0; i < rq.size(); i++) begin
            col = (sp ? 9'h100 + c[2:0] : {1'b0, c}) + i[8:0];
            chk(rq[i], tmem.exists(r*512 + col) ? tmem[r*512 + col] : {r[6:0], col});
        end
    endtask
    task automatic pg(input logic [7:0] c, input logic [15:0] r, input logic [8:0] n, input logic f);
        int w;
        w = wi;
        fail = f;
        run(nand_host_pkg::OP_PROGRAM, c, r, n);
        for (int i = 0; i < n; i++) tmem[r*512 + c + i] = 16'hc000 + 16'(w + i);
        chk({14'h0000, res.fail, res.status[6]}, {14'h0000, f, 1'b1});
    endtask
    initial begin
        repeat (4) @(negedge clock_i);
        resetn_i = 1'b1;
        rd(1'b0, 8'hfc, 16'h0005, 9'h006);
        stall = 1'b1;
        rd(1'b1, 8'h03, 16'h0007, 9'h005);
        rd(1'b0, 8'h00, 16'h0003, 9'h108);
        stall = 1'b0;
        pg(8'hfe, 16'h0009, 9'h004, 1'b0);
        rd(1'b0, 8'hfe, 16'h0009, 9'h004);
        pg(8'h10, 16'h0009, 9'h001, 1'b1);
        run(nand_host_pkg::OP_STATUS, 8'h00, 16'h0000, 9'h000);
        chk({14'h0000, res.status[6], res.status[0]}, 16'h0003);
        chk({15'h0000, viol}, 16'h0000);
        conclude();
    end
endmodule

/* verilog/nand_host.sv */
// host controller driving page read, program and status read on a nand part
`timescale 1ns/10ps
module nand_host #(
    parameter int DATA_W   = nand_host_pkg::DATA_W,
    parameter int BUSY_MAX = 4000
) (
    // clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 resetn_i,
    // user request
    input  wire logic                 req_valid_i,
    output logic                      req_ready_o,
    input  wire nand_host_pkg::req_t  req_i,
    // program data in
    input  wire logic                 wdata_valid_i,
    output logic                      wdata_ready_o,
    input  wire logic [DATA_W-1:0]    wdata_i,
    // read data out
    output logic                      rdata_valid_o,
    input  wire logic                 rdata_ready_i,
    output logic      [DATA_W-1:0]    rdata_o,
    // completion
    output nand_host_pkg::result_t    result_o,
    // nand pins
    output logic                      chip_en_n_o,
    output logic                      cmd_latch_o,
    output logic                      addr_latch_o,
    output logic                      write_strobe_n_o,
    output logic                      read_strobe_n_o,
    input  wire logic                 ready_busy_n_i,
    input  wire logic [DATA_W-1:0]    io_i,
    output logic      [DATA_W-1:0]    io_o,
    output logic      [DATA_W-1:0]    io_oe_o
);
    typedef enum {
        ST_IDLE, ST_PTR, ST_CMD, ST_ADDR, ST_WAIT_BUSY, ST_READ, ST_WDATA, ST_CONFIRM,
        ST_PROG_WAIT, ST_STAT_CMD, ST_STAT_READ, ST_DONE
    } state_t;

    // =========================================================
    // state
    // =========================================================
    state_t                     st_reg, st_next;
    nand_host_pkg::req_t        rq_reg, rq_next;
    logic [1:0]                 ac_reg, ac_next;
    logic [nand_host_pkg::LEN_W-1:0] left_reg, left_next;
    logic [nand_host_pkg::CNT_W-1:0] tm_reg, tm_next;
    logic [15:0]                bz_reg, bz_next;
    logic                       ph_reg, ph_next;
    logic                       cen_reg, cen_next, cle_reg, cle_next, ale_reg, ale_next;
    logic                       wen_reg, wen_next, ren_reg, ren_next;
    logic [DATA_W-1:0]          io_reg, io_next, oe_reg, oe_next;
    logic                       rrdy_reg, rrdy_next;
    nand_host_pkg::result_t     res_reg, res_next;
    logic                       rq_ack_reg, rq_ack_next;

    // =========================================================
    // read data buffer
    // =========================================================
    logic              buf_in_valid, buf_in_ready;
    logic [DATA_W-1:0] buf_in_data;

    word_buffer #(.WIDTH(DATA_W), .DEPTH(2)) u_rbuf (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (buf_in_data),
        .out_valid_o (rdata_valid_o),
        .out_ready_i (rdata_ready_i),
        .out_data_o  (rdata_o)
    );

    // sample io when read strobe rises after its low phase
    assign buf_in_valid  = (st_reg == ST_READ) && !ren_reg && (tm_reg == '0);
    assign buf_in_data   = io_i;
    assign wdata_ready_o = rrdy_reg;
    assign req_ready_o   = rq_ack_reg;

    function automatic logic [DATA_W-1:0] cmd_word(input logic [7:0] c);
        cmd_word = DATA_W'(c);
    endfunction

    function automatic logic [7:0] addr_byte(input nand_host_pkg::req_t r, input logic [1:0] i);
        case (i)
            2'd0: begin
                // x16 spare start: high column bits low
                addr_byte = (r.op == nand_host_pkg::OP_READ_SPARE) ? {5'h00, r.column[2:0]} : r.column;
            end
            2'd1: addr_byte = r.row[7:0];
            default: addr_byte = r.row[15:8];
        endcase
    endfunction

    // =========================================================
    // sequencer
    // =========================================================
    always_comb begin
        st_next     = st_reg;
        rq_next     = rq_reg;
        ac_next     = ac_reg;
        left_next   = left_reg;
        tm_next     = (tm_reg != '0) ? tm_reg - 1'b1 : tm_reg;
        bz_next     = bz_reg;
        ph_next     = ph_reg;
        cen_next    = cen_reg;
        cle_next    = cle_reg;
        ale_next    = ale_reg;
        wen_next    = wen_reg;
        ren_next    = ren_reg;
        io_next     = io_reg;
        oe_next     = oe_reg;
        rrdy_next   = 1'b0;
        res_next    = res_reg;
        rq_ack_next = 1'b0;
        res_next.done = 1'b0;
        case (st_reg)
            ST_IDLE: begin
                cen_next = 1'b1;
                if (req_valid_i && !rq_ack_reg) begin
                    rq_next     = req_i;
                    rq_ack_next = 1'b1;
                    left_next   = req_i.length;
                    cen_next    = 1'b0;
                    ph_next     = 1'b0;
                    tm_next     = '0;
                    // partial program count per page is kept by the user
                    st_next     = (req_i.op == nand_host_pkg::OP_STATUS) ? ST_STAT_CMD : ST_PTR;
                end
            end
            ST_PTR, ST_CMD, ST_CONFIRM, ST_STAT_CMD, ST_ADDR: begin
                if (tm_reg == '0) begin
                    if (!ph_reg) begin
                        cle_next = (st_reg != ST_ADDR);
                        ale_next = (st_reg == ST_ADDR);
                        wen_next = 1'b0;
                        oe_next  = '1;
                        case (st_reg)
                            // main read command returns pointer from spare
                            ST_PTR:     io_next = cmd_word((rq_reg.op == nand_host_pkg::OP_READ_SPARE) ?
                                                           nand_host_pkg::CMD_SPARE_READ :
                                                           nand_host_pkg::CMD_MAIN_READ);
                            ST_CMD:     io_next = cmd_word(nand_host_pkg::CMD_DATA_IN);
                            ST_CONFIRM: io_next = cmd_word(nand_host_pkg::CMD_CONFIRM);
                            ST_STAT_CMD: io_next = cmd_word(nand_host_pkg::CMD_STATUS);
                            default:    io_next = cmd_word(addr_byte(rq_reg, ac_reg));
                        endcase
                        tm_next = nand_host_pkg::CNT_W'(nand_host_pkg::STROBE_LOW_CYC);
                        ph_next = 1'b1;
                    end else if (!wen_reg) begin
                        wen_next = 1'b1;
                        tm_next  = nand_host_pkg::CNT_W'(nand_host_pkg::STROBE_HIGH_CYC);
                    end else begin
                        cle_next = 1'b0;
                        ale_next = 1'b0;
                        oe_next  = '0;
                        ph_next  = 1'b0;
                        case (st_reg)
                            // no read between pointer and setup
                            ST_PTR:      st_next = (rq_reg.op == nand_host_pkg::OP_PROGRAM) ? ST_CMD : ST_ADDR;
                            ST_CMD:      st_next = ST_ADDR;
                            ST_ADDR: begin
                                ac_next = ac_reg + 1'b1;
                                if (ac_reg == 2'(nand_host_pkg::ADDR_CYCLES - 1)) begin
                                    ac_next = '0;
                                    bz_next = '0;
                                    st_next = (rq_reg.op == nand_host_pkg::OP_PROGRAM) ? ST_WDATA : ST_WAIT_BUSY;
                                end
                            end
                            ST_CONFIRM:  begin
                                bz_next = '0;
                                st_next = ST_PROG_WAIT;
                            end
                            default: begin
                                tm_next = nand_host_pkg::CNT_W'(nand_host_pkg::WHR_CYC);
                                st_next = ST_STAT_READ;
                            end
                        endcase
                    end
                end
            end
            ST_WDATA: begin
                if (left_reg == '0) begin
                    st_next = ST_CONFIRM;
                end else if (tm_reg == '0) begin
                    if (!ph_reg) begin
                        if (wdata_valid_i && !rrdy_reg) begin
                            rrdy_next = 1'b1;
                            io_next   = wdata_i;
                            oe_next   = '1;
                            wen_next  = 1'b0;
                            ph_next   = 1'b1;
                            tm_next   = nand_host_pkg::CNT_W'(nand_host_pkg::STROBE_LOW_CYC);
                        end
                    end else if (!wen_reg) begin
                        wen_next = 1'b1;
                        tm_next  = nand_host_pkg::CNT_W'(nand_host_pkg::STROBE_HIGH_CYC);
                    end else begin
                        ph_next   = 1'b0;
                        oe_next   = '0;
                        left_next = left_reg - 1'b1;
                    end
                end
            end
            ST_WAIT_BUSY, ST_PROG_WAIT: begin
                // wait for page load; only status during program
                bz_next = bz_reg + 1'b1;
                if (bz_reg > 16'd2 && ready_busy_n_i) begin
                    st_next = (st_reg == ST_PROG_WAIT) ? ST_STAT_CMD : ST_READ;
                    tm_next = nand_host_pkg::CNT_W'(nand_host_pkg::STROBE_HIGH_CYC);
                end else if (bz_reg == 16'(BUSY_MAX)) begin
                    res_next.fail = 1'b1;
                    st_next       = ST_DONE;
                end
            end
            ST_READ: begin
                // one word per strobe, 64 ns cycle
                if (left_reg == '0) begin
                    // chip enable high ends sequential read
                    res_next.fail = 1'b0;
                    st_next       = ST_DONE;
                end else if (tm_reg == '0) begin
                    if (ren_reg) begin
                        // buffer full: stall with strobe high
                        if (buf_in_ready) begin
                            ren_next = 1'b0;
                            tm_next  = nand_host_pkg::CNT_W'(nand_host_pkg::STROBE_LOW_CYC);
                        end
                    end else begin
                        ren_next  = 1'b1;
                        left_next = left_reg - 1'b1;
                        tm_next   = nand_host_pkg::CNT_W'(nand_host_pkg::STROBE_HIGH_CYC);
                    end
                end
            end
            ST_STAT_READ: begin
                if (tm_reg == '0) begin
                    if (ren_reg) begin
                        ren_next = 1'b0;
                        tm_next  = nand_host_pkg::CNT_W'(nand_host_pkg::STROBE_LOW_CYC);
                    end else begin
                        ren_next = 1'b1;
                        // ready bit 6, fail bit 0; device flags fail
                        res_next.status = io_i[7:0];
                        res_next.fail   = io_i[nand_host_pkg::STAT_FAIL_BIT];
                        st_next = io_i[nand_host_pkg::STAT_READY_BIT] ? ST_DONE : ST_STAT_CMD;
                        tm_next = nand_host_pkg::CNT_W'(nand_host_pkg::STROBE_HIGH_CYC);
                    end
                end
            end
            ST_DONE: begin
                cen_next      = 1'b1;
                res_next.done = 1'b1;
                st_next       = ST_IDLE;
            end
            default: st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg     <= ST_IDLE;
            rq_reg     <= '0;
            ac_reg     <= '0;
            left_reg   <= '0;
            tm_reg     <= '0;
            bz_reg     <= '0;
            ph_reg     <= 1'b0;
            cen_reg    <= 1'b1;
            cle_reg    <= 1'b0;
            ale_reg    <= 1'b0;
            wen_reg    <= 1'b1;
            ren_reg    <= 1'b1;
            io_reg     <= '0;
            oe_reg     <= '0;
            rrdy_reg   <= 1'b0;
            res_reg    <= '0;
            rq_ack_reg <= 1'b0;
        end else begin
            st_reg     <= st_next;
            rq_reg     <= rq_next;
            ac_reg     <= ac_next;
            left_reg   <= left_next;
            tm_reg     <= tm_next;
            bz_reg     <= bz_next;
            ph_reg     <= ph_next;
            cen_reg    <= cen_next;
            cle_reg    <= cle_next;
            ale_reg    <= ale_next;
            wen_reg    <= wen_next;
            ren_reg    <= ren_next;
            io_reg     <= io_next;
            oe_reg     <= oe_next;
            rrdy_reg   <= rrdy_next;
            res_reg    <= res_next;
            rq_ack_reg <= rq_ack_next;
        end
    end

    assign chip_en_n_o      = cen_reg;
    assign cmd_latch_o      = cle_reg;
    assign addr_latch_o     = ale_reg;
    assign write_strobe_n_o = wen_reg;
    assign read_strobe_n_o  = ren_reg;
    assign io_o             = io_reg;
    assign io_oe_o          = oe_reg;
    assign result_o         = res_reg;

    // =========================================================
    // checks
    // =========================================================
    // latch enables exclusive
    latch_excl_a: assert property (@(posedge clock_i) disable iff (!resetn_i) !(cle_reg && ale_reg))
        else $error("command and address latch both high");
    strobe_excl_a: assert property (@(posedge clock_i) disable iff (!resetn_i) !(!wen_reg && !ren_reg))
        else $error("both strobes low");
    upper_zero_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (cle_reg || ale_reg) |-> io_reg[DATA_W-1:8] == '0) else $error("upper io not zero");
    // read strobe low holds for at least two cycles
    re_width_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $fell(ren_reg) |-> !ren_reg [*2]) else $error("read strobe low too short");
    we_width_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $fell(wen_reg) |-> !wen_reg [*2]) else $error("write strobe low too short");
    // data driven while write strobe low
    oe_on_write_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !wen_reg |-> oe_reg == '1) else $error("io not driven during write");
    no_drive_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !ren_reg |-> oe_reg == '0) else $error("io driven during read");
    done_pulse_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        res_reg.done |=> !res_reg.done) else $error("done longer than one cycle");
    prog_cover_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
        st_reg == ST_PROG_WAIT ##[1:1000] st_reg == ST_STAT_READ);
    read_cover_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
        st_reg == ST_READ ##[1:1000] st_reg == ST_DONE);
    stall_cover_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
        st_reg == ST_READ && !buf_in_ready);
endmodule

/* verilog/nand_host_pkg.sv */
// constants and types for the nand page read/program host controller
// Function
// - host issues the matching pointer command before the serial data input command.
// - pointer command may be followed directly by program setup, no read needed.
// - x16 part: upper eight data lines are zero during command and address cycles.
// - page read is read command plus three address cycles; command need not repeat.
// - spare read: low column bits pick start; x16 higher bits must be low.
// - main-area read command moves the pointer back from spare to main.
// - sequential read stays within a block; the host does not check this; chip enable high ends it.
// - at most 2 partial programs per main page, 3 per spare; the host does not count them, the user does.
// - program is data input command, three address cycles, then up to a page.
// - status read command, then read cycles return current status.
package nand_host_pkg;
    localparam int        DATA_W         = 16;
    localparam logic [7:0] CMD_MAIN_READ  = 8'h00;
    localparam logic [7:0] CMD_SPARE_READ = 8'h50;
    localparam logic [7:0] CMD_DATA_IN    = 8'h80;
    localparam logic [7:0] CMD_CONFIRM    = 8'h10;
    localparam logic [7:0] CMD_STATUS     = 8'h70;
    localparam int        ADDR_CYCLES    = 3;
    localparam int        STAT_READY_BIT = 6;
    localparam int        STAT_FAIL_BIT  = 0;
    localparam int        CLK_PERIOD_PS  = 4000;
    // strobe phase minimum times in ns; pins hold each phase at least one cycle past the rounded-up count
    localparam int        STROBE_LOW_NS  = 25;
    localparam int        STROBE_HIGH_NS = 25;
    localparam int        WHR_NS         = 60;
    localparam int        STROBE_LOW_CYC  = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int        STROBE_HIGH_CYC = (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int        WHR_CYC         = (WHR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int        CNT_W          = 8;
    localparam int        LEN_W          = 9;

    typedef enum logic [1:0] {
        OP_READ_MAIN,
        OP_READ_SPARE,
        OP_PROGRAM,
        OP_STATUS
    } op_t;

    typedef struct packed {
        op_t              op;
        logic [7:0]       column;
        logic [15:0]      row;
        logic [LEN_W-1:0] length;
    } req_t;

    typedef struct packed {
        logic       done;
        logic       fail;
        logic [7:0] status;
    } result_t;
endpackage

/* verilog/word_buffer.sv */
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/10ps
module word_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [PW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign push        = in_valid_i && (cnt_reg != (PW+1)'(DEPTH));
    assign pop         = out_ready_i && (cnt_reg != '0);
    assign in_ready_o  = cnt_reg != (PW+1)'(DEPTH);
    assign out_valid_o = cnt_reg != '0;
    assign out_data_o  = mem_reg[rd_reg];

    always_comb begin
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end
endmodule
